/* rtl/rme_pkg.sv */
// Constants and carrier types for the reset, mode-entry and latch-strobe block.
// Assumes a crystal-rate clock; machine cycles are derived by counting it.
`default_nettype none

package rme_pkg;

   // ************************************************************
   // Machine cycle and strobe timing in crystal clocks; reset holds in machine cycles
   // ************************************************************
   localparam int unsigned MC_CLKS_12      = 12;  // Default mode
   localparam int unsigned MC_CLKS_6       = 6;   // Double-speed mode
   localparam int unsigned STROBE_DIV_12   = 6;   // Latch strobe every 6 clocks
   localparam int unsigned STROBE_DIV_6    = 3;   // Latch strobe every 3 clocks
   localparam int unsigned RESET_QUAL_MC   = 2;   // Machine cycles of reset high
   localparam int unsigned HOST_HOLD_MC    = 10;  // Reset must exceed this for host mode

   localparam logic [2:0] PHASE_LAST_12    = 3'h5;
   localparam logic [2:0] PHASE_LAST_6     = 3'h2;
   localparam logic [2:0] PROGRAM_STORE_READ_STROBE_START_12    = 3'h3;
   localparam logic [2:0] PROGRAM_STORE_READ_STROBE_START_6     = 3'h2;
   localparam logic [2:0] PHASE_RESET      = 3'h0;

   // ************************************************************
   // Register field conventions
   // ************************************************************
   localparam logic [7:0] FIXED_ZERO_MASK  = 8'h00;  // Bits that always read zero
   localparam logic [7:0] FIXED_ONE_MASK   = 8'h00;  // Bits that always read one
   localparam logic [7:0] RESERVED_MASK    = 8'hfc;  // Reserved bits, written as zero
   localparam logic [7:0] SFR_RESET        = 8'h00;

   // ************************************************************
   // Pin carriers
   // ************************************************************
   typedef struct packed {
      logic latchOut;   // Address latch strobe, active high
      logic latchOeN;   // Low while the strobe pin is driven
      logic psenOut;    // Program store read strobe, active low
      logic psenOeN;    // Low while the read strobe pin is driven
   } strobe_pins_t;

   localparam strobe_pins_t PINS_RESET = '{latchOut: 1'b0, latchOeN: 1'b0,
                                           psenOut: 1'b1, psenOeN: 1'b1};

endpackage : rme_pkg

`default_nettype wire

/* rtl/reset_mode_entry_and_latch_strobe.sv */
// Reset qualification, host/normal mode entry, code-source strap and
// address latch strobe generation, plus register read/write bit conditioning.
// Assumes sys_clk is the crystal clock; pins arrive unsynchronised.
//
// Contract
// - Reset after two machine cycles of reset high
// - Read strobe falling during reset selects host mode
// - Host mode needs reset high over ten cycles
// - Code source follows external code select strap
// - Latch strobe marks low address byte
// - Default mode strobe at crystal over six
// - Double-speed mode strobe at crystal over three
// - Skip one strobe per external data access
// - Latch strobe off bit stops strobe
// - Strobe pin becomes programming pulse in host mode
// - Reserved bits written zero, read undefined
// - Fixed zero bits write and read zero
// - Fixed one bits write and read one
// - Read strobe stays high for internal execution
`default_nettype none

module reset_mode_entry_and_latch_strobe #(
   parameter int unsigned RST_CNT_W = 8
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic                   clkEn,
   input  wire logic                   resetPin,
   input  wire logic                   psenIn,
   input  wire logic                   latchIn,
   input  wire logic                   externalCodeSelect,
   input  wire logic                   doubleSpeed,
   input  wire logic                   latchStrobeOff,
   input  wire logic                   extDataAccess,
   input  wire logic [7:0]             sfrRawRead,
   input  wire logic [7:0]             sfrRawWrite,
   output var  rme_pkg::strobe_pins_t  strobePins,
   output var  logic                   deviceReset,
   output var  logic                   hostMode,
   output var  logic                   fetchExternal,
   output var  logic                   programmingPulse,
   output var  logic [7:0]             sfrReadData,
   output var  logic [7:0]             sfrWriteData
);

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (RST_CNT_W < 8) begin : g_bad_width
      $error("RST_CNT_W too narrow for the host-mode hold count");
   end
   if ((rme_pkg::FIXED_ZERO_MASK & rme_pkg::FIXED_ONE_MASK) != 8'h00) begin : g_bad_mask
      $error("A register bit cannot be fixed at both zero and one");
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [3:0] syncMeta_ff;
   logic [3:0] syncOut_ff;
   logic       psenPrev_ff;
   logic       latchPrev_ff;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle pin levels, so no false edge follows reset
         syncMeta_ff  <= 4'h2;
         syncOut_ff   <= 4'h2;
         psenPrev_ff  <= 1'b1;
         latchPrev_ff <= 1'b0;
      end else if (clkEn) begin
         syncMeta_ff  <= {externalCodeSelect, latchIn, psenIn, resetPin};
         syncOut_ff   <= syncMeta_ff;
         psenPrev_ff  <= syncOut_ff[1];
         latchPrev_ff <= syncOut_ff[2];
      end
   end

   wire rstSync   = syncOut_ff[0];
   wire psenSync  = syncOut_ff[1];
   wire latchSync = syncOut_ff[2];
   wire ecsSync   = syncOut_ff[3];
   wire psenFall  = psenPrev_ff & ~psenSync;
   wire latchFall = latchPrev_ff & ~latchSync;

   // ************************************************************
   // Reset qualification and mode entry
   // ************************************************************
   logic [RST_CNT_W-1:0] rstHighCnt_ff;
   logic [RST_CNT_W-1:0] nxt_rstHighCnt;
   logic                 inReset_ff;
   logic                 hostMode_ff;
   logic                 fallSeen_ff;
   logic                 fetchExternal_ff;

   wire [RST_CNT_W-1:0] mcClks   = doubleSpeed ? RST_CNT_W'(rme_pkg::MC_CLKS_6)
                                               : RST_CNT_W'(rme_pkg::MC_CLKS_12);
   wire [RST_CNT_W-1:0] qualLast = RST_CNT_W'(rme_pkg::RESET_QUAL_MC * mcClks - 1);
   wire [RST_CNT_W-1:0] hostLim  = RST_CNT_W'(rme_pkg::HOST_HOLD_MC * mcClks);
   wire                 cntSat   = &rstHighCnt_ff;
   wire                 hostOk   = fallSeen_ff && (rstHighCnt_ff > hostLim);
   wire                 rstEnd   = inReset_ff && !rstSync;
   // Own fetch strobes still ripple through the synchroniser after release,
   // so a fall counts only one machine cycle past qualification
   wire                 fallWin  = rstHighCnt_ff > (qualLast + mcClks);

   assign nxt_rstHighCnt = !rstSync ? '0 :
                           cntSat   ? rstHighCnt_ff : rstHighCnt_ff + 1'b1;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstHighCnt_ff <= '0;
         inReset_ff    <= 1'b0;
         hostMode_ff   <= 1'b0;
         fallSeen_ff   <= 1'b0;
      end else if (clkEn) begin
         rstHighCnt_ff <= nxt_rstHighCnt;
         if (rstSync && rstHighCnt_ff == qualLast) begin
            inReset_ff <= 1'b1;
         end else if (!rstSync) begin
            inReset_ff <= 1'b0;
         end
         if (rstEnd) begin
            hostMode_ff <= hostOk;
         end
         if (rstSync && psenFall && fallWin) begin
            fallSeen_ff <= 1'b1;
         end else if (!rstSync) begin
            fallSeen_ff <= 1'b0;
         end
      end
   end

   // Strap caught only while reset stands, so a moving pin cannot switch source mid-run
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fetchExternal_ff <= 1'b0;
      end else if (clkEn && inReset_ff) begin
         fetchExternal_ff <= !ecsSync;
      end
   end

   // ************************************************************
   // Strobe phase and pin drive
   // ************************************************************
   logic [2:0]            phase_ff;
   logic                  skipDone_ff;
   rme_pkg::strobe_pins_t pins_ff;
   rme_pkg::strobe_pins_t nxt_pins;
   logic                  progPulse_ff;

   wire [2:0] phaseLast = doubleSpeed ? rme_pkg::PHASE_LAST_6 : rme_pkg::PHASE_LAST_12;
   wire [2:0] psenStart = doubleSpeed ? rme_pkg::PROGRAM_STORE_READ_STROBE_START_6 : rme_pkg::PROGRAM_STORE_READ_STROBE_START_12;
   wire       running   = !inReset_ff && !hostMode_ff;
   wire       phaseZero = phase_ff == rme_pkg::PHASE_RESET;
   wire       skipNow   = extDataAccess && !skipDone_ff;
   wire       aleFire   = running && phaseZero && !skipNow && !latchStrobeOff;
   wire       psenFire  = running && fetchExternal_ff && !extDataAccess
                          && (phase_ff >= psenStart);

   // Read strobe pin released in reset and host mode, latch strobe pin in host mode only, so the host can force them
   assign nxt_pins = '{latchOut: aleFire,
                       latchOeN: hostMode_ff,
                       psenOut:  !psenFire,
                       psenOeN:  inReset_ff || hostMode_ff};

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= rme_pkg::PHASE_RESET;
      end else if (clkEn) begin
         if (!running || phase_ff >= phaseLast) begin
            phase_ff <= rme_pkg::PHASE_RESET;
         end else begin
            phase_ff <= phase_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         skipDone_ff <= 1'b0;
      end else if (clkEn) begin
         if (extDataAccess && phaseZero) begin
            skipDone_ff <= 1'b1;
         end else if (!extDataAccess) begin
            skipDone_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_ff      <= rme_pkg::PINS_RESET;
         progPulse_ff <= 1'b0;
      end else if (clkEn) begin
         pins_ff      <= nxt_pins;
         progPulse_ff <= hostMode_ff && latchFall;
      end
   end

   // ************************************************************
   // Register bit conditioning
   // ************************************************************
   logic [7:0] sfrRead_ff;
   logic [7:0] sfrWrite_ff;

   // Reserved bits pass through on read: their value carries no promise
   wire [7:0] nxt_sfrRead  = (sfrRawRead & ~rme_pkg::FIXED_ZERO_MASK)
                             | rme_pkg::FIXED_ONE_MASK;
   wire [7:0] nxt_sfrWrite = (sfrRawWrite & ~(rme_pkg::FIXED_ZERO_MASK | rme_pkg::RESERVED_MASK))
                             | rme_pkg::FIXED_ONE_MASK;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfrRead_ff  <= rme_pkg::SFR_RESET;
         sfrWrite_ff <= rme_pkg::SFR_RESET;
      end else if (clkEn) begin
         sfrRead_ff  <= nxt_sfrRead;
         sfrWrite_ff <= nxt_sfrWrite;
      end
   end

   assign strobePins       = pins_ff;
   assign deviceReset      = inReset_ff;
   assign hostMode         = hostMode_ff;
   assign fetchExternal    = fetchExternal_ff;
   assign programmingPulse = progPulse_ff;
   assign sfrReadData      = sfrRead_ff;
   assign sfrWriteData     = sfrWrite_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk iff clkEn);
   endclocking
   default disable iff (!reset_n);

   AST_RESET_QUAL: assert property (
      (rstSync && rstHighCnt_ff == qualLast && !inReset_ff) |=> inReset_ff)
      else $error("Reset not taken after two machine cycles");

   AST_HOST_ENTRY: assert property (
      (rstEnd && hostOk) |=> hostMode_ff)
      else $error("Host mode not entered after strobe fall in reset");

   AST_NORMAL_ENTRY: assert property (
      (rstEnd && rstHighCnt_ff <= hostLim) |=> !hostMode_ff)
      else $error("Host mode entered with too short a reset");

   AST_FETCH_SEL: assert property (
      inReset_ff |=> fetchExternal_ff == !$past(ecsSync))
      else $error("Code source does not follow the strap");

   AST_ALE_PHASE: assert property (
      pins_ff.latchOut |-> $past(phaseZero) && !$past(inReset_ff))
      else $error("Latch strobe outside phase zero");

   AST_ALE_RATE: assert property (
      (running && phaseZero && !doubleSpeed) ##1 (running && !doubleSpeed)[*5]
      |=> phaseZero)
      else $error("Latch strobe period not six clocks");

   AST_ALE_RATE_X2: assert property (
      (running && phaseZero && doubleSpeed) ##1 (running && doubleSpeed)[*2]
      |=> phaseZero)
      else $error("Latch strobe period not three clocks");

   AST_ALE_SKIP: assert property (
      (extDataAccess && !skipDone_ff && phaseZero) |=> !pins_ff.latchOut && skipDone_ff)
      else $error("Latch strobe not skipped for data access");

   AST_ALE_OFF: assert property (
      latchStrobeOff |=> !pins_ff.latchOut)
      else $error("Latch strobe emitted while switched off");

   AST_PROGRAMMING_PULSE_INPUT_PIN: assert property (
      hostMode_ff |=> pins_ff.latchOeN && !pins_ff.latchOut)
      else $error("Strobe pin driven in host mode");

   AST_FIXED_BITS: assert property (
      ((sfrRead_ff & rme_pkg::FIXED_ZERO_MASK) == 8'h00)
      && ((sfrRead_ff & rme_pkg::FIXED_ONE_MASK) == rme_pkg::FIXED_ONE_MASK))
      else $error("Fixed register bits read wrong");

   AST_PROGRAM_STORE_READ_STROBE_INT: assert property (
      !fetchExternal_ff |=> pins_ff.psenOut)
      else $error("Read strobe active during internal execution");

   AST_RESET_IDLE: assert property (
      inReset_ff |=> !pins_ff.latchOut && pins_ff.psenOut && pins_ff.psenOeN)
      else $error("Strobes active during reset");

   COV_HOST: cover property (rstEnd && hostOk);
   COV_NORMAL: cover property (rstEnd && !hostOk ##1 running ##6 pins_ff.latchOut);
   COV_SKIP: cover property (extDataAccess && phaseZero && !skipDone_ff && running);
   COV_PROGRAMMING_PULSE_INPUT: cover property (progPulse_ff);

endmodule : reset_mode_entry_and_latch_strobe

`default_nettype wire

/* verification/far_side_model.sv */
// Far-side model: external memory pins plus a programming host.
// Assumes the strobe pins have pull-ups and the host drives only released pins.
`default_nettype none

module far_side_model (
   input  wire logic                  resetReq,
   input  wire logic                  hostPsenLow,
   input  wire logic                  hostProgLow,
   input  wire rme_pkg::strobe_pins_t strobePins,
   output logic                       resetPin,
   output logic                       psenIn,
   output logic                       latchIn
);
   timeunit 1ns;
   timeprecision 100ps;

   // Host holds reset for as long as the bench asks
   assign resetPin = resetReq;
   // Forced falling edge only while the device has released the pin
   assign psenIn = !strobePins.psenOeN ? strobePins.psenOut : !hostPsenLow;
   // Programming pulses only land when the strobe pin is released
   assign latchIn = !strobePins.latchOeN ? strobePins.latchOut : !hostProgLow;

endmodule : far_side_model

`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the reset, mode-entry and latch-strobe block.
// Assumes the far-side model resolves the strobe pins; clkEn stays high.
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int CYCLE_LIMIT = 20000;

   logic                  sys_clk, reset_n, resetReq, hostPsenLow, hostProgLow;
   logic                  externalCodeSelect, doubleSpeed, latchStrobeOff, extDataAccess;
   logic [7:0]            sfrRawRead, sfrRawWrite, sfrReadData, sfrWriteData;
   logic                  resetPin, psenIn, latchIn;
   rme_pkg::strobe_pins_t strobePins;
   logic                  deviceReset, hostMode, fetchExternal, programmingPulse;
   int                    badCount, checkCount, latchCount, psenLowCount, progCount;
   int                    cycleCount;

   reset_mode_entry_and_latch_strobe reset_mode_entry_and_latch_strobe_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1), .resetPin(resetPin),
      .psenIn(psenIn), .latchIn(latchIn), .externalCodeSelect(externalCodeSelect),
      .doubleSpeed(doubleSpeed), .latchStrobeOff(latchStrobeOff),
      .extDataAccess(extDataAccess), .sfrRawRead(sfrRawRead), .sfrRawWrite(sfrRawWrite),
      .strobePins(strobePins), .deviceReset(deviceReset), .hostMode(hostMode),
      .fetchExternal(fetchExternal), .programmingPulse(programmingPulse),
      .sfrReadData(sfrReadData), .sfrWriteData(sfrWriteData));

   far_side_model far_side_model_inst (
      .resetReq(resetReq), .hostPsenLow(hostPsenLow), .hostProgLow(hostProgLow),
      .strobePins(strobePins), .resetPin(resetPin), .psenIn(psenIn), .latchIn(latchIn));

   // ************************************************************
   // Clock, pulse counters and hang guard
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (strobePins.latchOut === 1'b1) latchCount++;
      if (strobePins.psenOut === 1'b0) psenLowCount++;
      if (programmingPulse === 1'b1) progCount++;
      cycleCount++;
      if (cycleCount == CYCLE_LIMIT) begin
         badCount++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (badCount == 0 && checkCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] seen, input logic [7:0] expected);
      checkCount++;
      if (seen !== expected) begin
         badCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle

   // Latch and read-strobe activity seen over a window of n clocks
   task automatic window(input int n, output int lat, output int psl);
      int l0, p0;
      l0 = latchCount;
      p0 = psenLowCount;
      idle(n);
      lat = latchCount - l0;
      psl = psenLowCount - p0;
   endtask : window

   // Reset pin held for hold clocks; optional forced read-strobe fall inside
   task automatic pin_reset(input int hold, input logic psenEdge, input logic strap);
      externalCodeSelect = strap;
      resetReq = 1'b1;
      idle(40);
      hostPsenLow = psenEdge;
      idle(hold - 50);
      hostPsenLow = 1'b0;
      idle(10);
      resetReq = 1'b0;
      idle(6);
   endtask : pin_reset

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_reset_qual();
      int lat, psl;
      resetReq = 1'b1;
      idle(15);
      resetReq = 1'b0;
      idle(20);
      check(deviceReset, 1'b0);
      resetReq = 1'b1;
      idle(20);
      check(deviceReset, 1'b0);
      idle(12);
      check(deviceReset, 1'b1);
      check(strobePins, rme_pkg::PINS_RESET);
      window(30, lat, psl);
      check(lat, 0);
      resetReq = 1'b0;
      idle(6);
      check({deviceReset, hostMode}, 2'h0);
   endtask : test_reset_qual

   task automatic test_ext_code();
      int lat, psl;
      pin_reset(60, 1'b0, 1'b0);
      check(fetchExternal, 1'b1);
      check(strobePins.latchOeN, 1'b0);
      window(60, lat, psl);
      check(lat, 10);
      check(psl > 0, 1'b1);
      doubleSpeed = 1'b1;
      idle(6);
      window(60, lat, psl);
      check(lat, 20);
      doubleSpeed = 1'b0;
      idle(12);
      window(20, lat, psl);
      extDataAccess = 1'b1;
      idle(1);
      window(10, lat, psl);
      check(psl, 0);
      extDataAccess = 1'b0;
      window(30, lat, psl);
      latchStrobeOff = 1'b1;
      idle(2);
      window(60, lat, psl);
      check(lat, 0);
      latchStrobeOff = 1'b0;
      idle(2);
   endtask : test_ext_code

   // One strobe lost per data access inside a 60-clock window
   task automatic test_skip();
      int l0;
      l0 = latchCount;
      idle(20);
      extDataAccess = 1'b1;
      idle(10);
      extDataAccess = 1'b0;
      idle(30);
      check(latchCount - l0, 9);
   endtask : test_skip

   task automatic test_int_code();
      int lat, psl;
      pin_reset(60, 1'b0, 1'b1);
      check(fetchExternal, 1'b0);
      window(60, lat, psl);
      check(psl, 0);
      check(lat, 10);
   endtask : test_int_code

   task automatic test_host();
      int p0;
      pin_reset(200, 1'b1, 1'b0);
      check(hostMode, 1'b1);
      check({strobePins.latchOeN, strobePins.psenOeN}, 2'h3);
      p0 = progCount;
      repeat (3) begin
         hostProgLow = 1'b1;
         idle(3);
         hostProgLow = 1'b0;
         idle(5);
      end
      check(progCount - p0, 3);
      pin_reset(200, 1'b0, 1'b0);
      check(hostMode, 1'b0);
      pin_reset(70, 1'b1, 1'b0);
      check(hostMode, 1'b0);
   endtask : test_host

   task automatic test_sfr();
      logic [7:0] vals [4] = '{8'hff, 8'h5a, 8'ha5, 8'h00};
      logic [7:0] expRd;
      foreach (vals[i]) begin
         sfrRawWrite = vals[i];
         sfrRawRead = vals[i];
         idle(1);
         expRd = (vals[i] & ~rme_pkg::FIXED_ZERO_MASK) | rme_pkg::FIXED_ONE_MASK;
         check(sfrWriteData, (vals[i] & ~(rme_pkg::RESERVED_MASK | rme_pkg::FIXED_ZERO_MASK))
               | rme_pkg::FIXED_ONE_MASK);
         check(sfrReadData & ~rme_pkg::RESERVED_MASK, expRd & ~rme_pkg::RESERVED_MASK);
      end
   endtask : test_sfr

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {badCount, checkCount, latchCount, psenLowCount, progCount, cycleCount} = '0;
      reset_n = 1'b0;
      {resetReq, hostPsenLow, hostProgLow, externalCodeSelect} = 4'h0;
      {doubleSpeed, latchStrobeOff, extDataAccess} = 3'h0;
      sfrRawRead = 8'h00;
      sfrRawWrite = 8'h00;
      idle(8);
      reset_n = 1'b1;
      idle(2);
      test_reset_qual();
      test_ext_code();
      test_skip();
      test_int_code();
      test_host();
      test_sfr();
      report_and_stop();
   end

endmodule : tb

`default_nettype wire
